// ==== rtl/fac_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - leave lock overlay: 90 then 00 or 03
// - secure unlock two needs 55 at 2AA
// - buffer count at most 256, same sector
// - abort recovery is AA, 55, F0 sequence
module fac_host #(
  parameter int unsigned AW = 26
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // flash pins
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o,
  output logic [AW-1:0]    addr_o,
  output logic [15:0]      dq_o,
  output logic             dq_oe_o,
  input  wire logic [15:0] dq_i,
  // interrupt
  output logic             irq_o
);
  logic             rs1_q, rs_n_q;
  logic [15:0]      dq1_q, dq2_q;
  fac_pkg::fac_bus_st_t st_q, st_d;
  fac_pkg::fac_view_t   vw_q, vw_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             wr_q, wr_d;
  logic [7:0]       cd_q, cd_d;
  logic [AW-1:0]    ad_q, ad_d, sa_q, sa_d;
  logic [15:0]      rd_q, rd_d;
  logic [8:0]       wc_q, wc_d;
  logic             srp_q, srp_d, abf_q, abf_d;
  logic [31:0]      prd_q, prd_d;
  logic             prdy_q, prdy_d, perr_q, perr_d;
  logic [fac_pkg::EV_W-1:0] ev_q, ev_d, msk_q, msk_d;
  logic             irq_q, irq_d;
  logic             ce_q, ce_d, we_q, we_d, oe_q, oe_d, dq_oe_q, dq_oe_d;
  logic [7:0]       err_q, err_d;
  logic             acc, issue;
  logic [fac_pkg::EV_W-1:0] ev_set;

  // reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs1_q  <= 1'b0;
      rs_n_q <= 1'b0;
    end else begin
      rs1_q  <= 1'b1;
      rs_n_q <= rs1_q;
    end
  end

  // data pins cross in through two flops
  always_ff @(posedge ref_clk_i or negedge rs_n_q) begin
    if (!rs_n_q) begin
      dq1_q <= 16'h0000;
      dq2_q <= 16'h0000;
    end else if (clk_en_i) begin
      dq1_q <= dq_i;
      dq2_q <= dq1_q;
    end
  end

  function automatic logic is_cmd(input logic [AW-1:0] a, input logic [7:0] d,
                                  input logic [11:0] ea, input logic [7:0] ed,
                                  input logic any);
    is_cmd = (d == ed) && (any || a[11:0] == ea);
  endfunction

  assign acc   = psel_i && penable_i && !prdy_q;
  assign issue = acc && pwrite_i && paddr_i == fac_pkg::REG_CMD
                 && st_q == fac_pkg::FAC_IDLE;

  // command tracker, bus cycle engine and registers
  always_comb begin
    st_d = st_q; vw_d = vw_q; cnt_d = cnt_q; wr_d = wr_q; cd_d = cd_q;
    ad_d = ad_q; sa_d = sa_q; rd_d = rd_q; wc_d = wc_q; srp_d = srp_q;
    prd_d = prd_q; prdy_d = 1'b0; perr_d = 1'b0; msk_d = msk_q;
    ce_d = ce_q; we_d = we_q; oe_d = oe_q; err_d = err_q;
    ev_set = '0;
    if (acc) begin
      prdy_d = 1'b1;
      if (pwrite_i) begin
        case (paddr_i)
          fac_pkg::REG_CMD: begin
            if (st_q != fac_pkg::FAC_IDLE) perr_d = 1'b1; // busy refuses
            else begin
              wr_d = pwdata_i[31:30] == fac_pkg::OP_WRITE;
              cd_d = pwdata_i[7:0];
              ad_d = AW'(pwdata_i[27:16]) | (ad_q & ~AW'(12'hfff));
              st_d = fac_pkg::FAC_SETUP;
            end
          end
          fac_pkg::REG_ADDR:   ad_d = pwdata_i[AW-1:0];
          fac_pkg::REG_MASK:   msk_d = pwdata_i[fac_pkg::EV_W-1:0];
          fac_pkg::REG_STATUS: ;
          fac_pkg::REG_ERR:    err_d = err_q & ~pwdata_i[7:0];
          default:             perr_d = 1'b1;
        endcase
      end else begin
        case (paddr_i)
          fac_pkg::REG_CMD:    prd_d = {28'h0000000, vw_q};
          fac_pkg::REG_ADDR:   prd_d = 32'(ad_q);
          fac_pkg::REG_RDATA:  prd_d = {16'h0000, rd_q};
          fac_pkg::REG_STATUS: prd_d = {15'h0000, st_q != fac_pkg::FAC_IDLE,
                                        16'(ev_q)};
          fac_pkg::REG_MASK:   prd_d = 32'(msk_q);
          fac_pkg::REG_ERR:    prd_d = {24'h000000, err_q};
          default: begin
            prd_d  = 32'h00000000;
            perr_d = 1'b1;
          end
        endcase
      end
    end
    // pin sequencing: setup, strobe low, release
    case (st_q)
      fac_pkg::FAC_IDLE: ;
      fac_pkg::FAC_SETUP: begin
        ce_d = 1'b0; we_d = !wr_q; oe_d = wr_q;
        cnt_d = 2'(fac_pkg::STROBE_CYC); st_d = fac_pkg::FAC_STROBE;
      end
      fac_pkg::FAC_STROBE: begin
        if (cnt_q != 2'h0) cnt_d = cnt_q - 2'h1;
        else begin
          we_d = 1'b1; oe_d = 1'b1; st_d = fac_pkg::FAC_HOLD;
          if (!wr_q) rd_d = dq2_q; // sampled a sync delay after oe fall
        end
      end
      fac_pkg::FAC_HOLD: begin
        ce_d = 1'b1; st_d = fac_pkg::FAC_IDLE;
        if (!wr_q) begin
          if (srp_q) srp_d = 1'b0; // one status read only
          if (vw_q == fac_pkg::FAC_SECPG || vw_q == fac_pkg::FAC_LOCKPG) begin
            if (rd_q[fac_pkg::DQ_ABORT_BIT] && vw_q == fac_pkg::FAC_SECPG) begin
              vw_d = fac_pkg::FAC_ABORT; ev_set[fac_pkg::EV_ABORT] = 1'b1;
            end else if (rd_q[fac_pkg::SR_READY_BIT] && srp_q) begin
              vw_d = fac_pkg::FAC_ARRAY; ev_set[fac_pkg::EV_DONE] = 1'b1;
            end
          end
        end else begin
          // follow the device state on each written cycle
          case (vw_q)
            fac_pkg::FAC_ARRAY: ;
            fac_pkg::FAC_LOCK, fac_pkg::FAC_QUERY, fac_pkg::FAC_SEC: begin
              if (is_cmd(ad_q, cd_q, 12'h000, fac_pkg::CMD_RESET, 1'b1))
                vw_d = fac_pkg::FAC_ARRAY;
              else if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_SR_READ, 1'b0))
                srp_d = 1'b1;
              else if (vw_q == fac_pkg::FAC_LOCK && cd_q == fac_pkg::CMD_EXIT_ENT)
                vw_d = fac_pkg::FAC_LOCKX;
              else if (vw_q == fac_pkg::FAC_LOCK && cd_q == fac_pkg::CMD_PROGRAM)
                vw_d = fac_pkg::FAC_LOCKPG;
              else if (vw_q == fac_pkg::FAC_SEC &&
                       is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_UNLOCK1, 1'b0))
                vw_d = fac_pkg::FAC_SECUL1;
            end
            fac_pkg::FAC_LOCKX: begin
              if (cd_q == fac_pkg::CMD_EXIT || cd_q == fac_pkg::CMD_EXIT_ALT)
                vw_d = fac_pkg::FAC_ARRAY;
            end
            fac_pkg::FAC_LOCKPG: begin
              if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_SR_READ, 1'b0))
                srp_d = 1'b1;
              else err_d[0] = 1'b1; // reset/exit ignored while busy
            end
            fac_pkg::FAC_SECUL1, fac_pkg::FAC_ABORT: begin
              if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK2, fac_pkg::CMD_UNLOCK2, 1'b0))
                vw_d = fac_pkg::FAC_SECUL2;
              else if (vw_q == fac_pkg::FAC_ABORT)
                vw_d = is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_UNLOCK1, 1'b0)
                       ? fac_pkg::FAC_SECUL1 : fac_pkg::FAC_ABORT;
              else if (abf_q) vw_d = fac_pkg::FAC_ABORT; // bad second unlock
              else if (cd_q == fac_pkg::CMD_RESET) vw_d = fac_pkg::FAC_ARRAY;
              else if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_SR_READ, 1'b0)) begin
                srp_d = 1'b1; vw_d = fac_pkg::FAC_SEC;
              end
            end
            fac_pkg::FAC_SECUL2: begin
              if (cd_q == fac_pkg::CMD_RESET) vw_d = fac_pkg::FAC_SEC;
              else if (abf_q) vw_d = fac_pkg::FAC_ABORT; // only reset recovers
              else if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_PROGRAM, 1'b0))
                vw_d = fac_pkg::FAC_SECPG; // one data write follows
              else if (cd_q == fac_pkg::CMD_WB_LOAD) begin
                sa_d = ad_q; vw_d = fac_pkg::FAC_SECWC;
              end else if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_EXIT_ENT, 1'b0))
                vw_d = fac_pkg::FAC_SECX;
            end
            fac_pkg::FAC_SECWC: begin
              // a count over the limit, or a count written off the start address, moves the view to abort
              if (9'(cd_q) + 9'h001 > 9'(fac_pkg::WB_MAX_WORDS) || ad_q != sa_q) begin
                vw_d = fac_pkg::FAC_ABORT; err_d[1] = 1'b1;
              end else begin
                wc_d = 9'(cd_q) + 9'h001; vw_d = fac_pkg::FAC_SECWD;
              end
            end
            fac_pkg::FAC_SECWD: begin
              if (wc_q == 9'h000)
                vw_d = fac_pkg::FAC_SECPG; // any write after the last word ends loading, whatever its data
              else if (ad_q[AW-1:8] != sa_q[AW-1:8]) begin
                vw_d = fac_pkg::FAC_ABORT; err_d[2] = 1'b1;
              end else wc_d = wc_q - 9'h001;
            end
            fac_pkg::FAC_SECPG: begin
              if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_SR_READ, 1'b0))
                srp_d = 1'b1;
              else if (!rd_q[fac_pkg::SR_READY_BIT]) err_d[3] = 1'b1; // ignored
              else if (cd_q == fac_pkg::CMD_RESET) vw_d = fac_pkg::FAC_ARRAY;
              else if (cd_q == fac_pkg::CMD_SR_CLEAR) vw_d = fac_pkg::FAC_SEC;
            end
            fac_pkg::FAC_SECX: begin
              if (cd_q == fac_pkg::CMD_EXIT) vw_d = fac_pkg::FAC_ARRAY;
              else if (is_cmd(ad_q, cd_q, fac_pkg::ADDR_UNLOCK1, fac_pkg::CMD_SR_READ, 1'b0)) begin
                srp_d = 1'b1; vw_d = fac_pkg::FAC_SEC;
              end
            end
            default: vw_d = fac_pkg::FAC_ARRAY;
          endcase
        end
        if (err_d != err_q) ev_set[fac_pkg::EV_ERR] = 1'b1;
      end
      default: st_d = fac_pkg::FAC_IDLE;
    endcase
    // overlay entry is tracked from software-set view: writes of view via REG_CMD op 3
    if (issue && pwdata_i[31:30] == 2'h3) begin
      vw_d = fac_pkg::fac_view_t'(pwdata_i[3:0]);
      st_d = fac_pkg::FAC_IDLE;
    end
    // abort flag lives only through the recovery unlocks; any abort entry raises the event
    abf_d = vw_d == fac_pkg::FAC_ABORT ||
            (abf_q && (vw_d == fac_pkg::FAC_SECUL1 || vw_d == fac_pkg::FAC_SECUL2));
    if (vw_d == fac_pkg::FAC_ABORT && vw_q != fac_pkg::FAC_ABORT)
      ev_set[fac_pkg::EV_ABORT] = 1'b1;
    dq_oe_d = wr_d && !ce_d; // registered so the enable comes straight from a flop
    // set wins over write-one-clear
    ev_d = ev_q;
    if (acc && pwrite_i && paddr_i == fac_pkg::REG_STATUS)
      ev_d = ev_q & ~pwdata_i[fac_pkg::EV_W-1:0];
    ev_d = ev_d | ev_set;
    irq_d = |(ev_d & msk_d);
  end

  // register stage
  always_ff @(posedge ref_clk_i or negedge rs_n_q) begin
    if (!rs_n_q) begin
      st_q <= fac_pkg::FAC_IDLE; vw_q <= fac_pkg::FAC_ARRAY;
      cnt_q <= 2'h0; wr_q <= 1'b0; cd_q <= 8'h00;
      ad_q <= '0; sa_q <= '0; rd_q <= 16'h0000; wc_q <= 9'h000; srp_q <= 1'b0; abf_q <= 1'b0;
      prd_q <= 32'h00000000; prdy_q <= 1'b0; perr_q <= 1'b0;
      ev_q <= '0; msk_q <= '0; irq_q <= 1'b0; err_q <= 8'h00;
      ce_q <= 1'b1; we_q <= 1'b1; oe_q <= 1'b1; dq_oe_q <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d; vw_q <= vw_d;
      cnt_q <= cnt_d; wr_q <= wr_d; cd_q <= cd_d;
      ad_q <= ad_d; sa_q <= sa_d; rd_q <= rd_d; wc_q <= wc_d; srp_q <= srp_d; abf_q <= abf_d;
      prd_q <= prd_d; prdy_q <= prdy_d; perr_q <= perr_d;
      ev_q <= ev_d; msk_q <= msk_d; irq_q <= irq_d; err_q <= err_d;
      ce_q <= ce_d; we_q <= we_d; oe_q <= oe_d; dq_oe_q <= dq_oe_d;
    end
  end

  // outputs straight from flops
  assign prdata_o  = prd_q;
  assign pready_o  = prdy_q;
  assign pslverr_o = perr_q;
  assign ce_n_o    = ce_q;
  assign we_n_o    = we_q;
  assign oe_n_o    = oe_q;
  assign addr_o    = ad_q;
  assign dq_o      = {8'h00, cd_q};
  assign dq_oe_o   = dq_oe_q; // drive only during a write cycle
  assign irq_o     = irq_q;
endmodule
`default_nettype wire

// ==== rtl/fac_pkg.sv ====
package fac_pkg;
  // flash command cycle addresses and data
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_SR_READ  = 8'h70;
  localparam logic [7:0]  CMD_SR_CLEAR = 8'h71;
  localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CMD_WB_LOAD  = 8'h25;
  localparam logic [7:0]  CMD_EXIT_ENT = 8'h90;
  localparam logic [7:0]  CMD_EXIT     = 8'h00;
  localparam logic [7:0]  CMD_EXIT_ALT = 8'h03;
  localparam logic [7:0]  CMD_CONFIRM  = 8'h29;
  localparam int unsigned WB_MAX_WORDS = 256;
  // status register bit positions
  localparam int unsigned SR_READY_BIT = 7;
  localparam int unsigned SR_ABORT_BIT = 3;
  localparam int unsigned DQ_ABORT_BIT = 1;
  // apb register offsets
  localparam logic [7:0] REG_CMD    = 8'h00; // w: [7:0] data, [27:16] addr, [31:30] op
  localparam logic [7:0] REG_ADDR   = 8'h04; // full flash word address
  localparam logic [7:0] REG_RDATA  = 8'h08; // r: last read data
  localparam logic [7:0] REG_STATUS = 8'h0c; // r: busy, bits; w1c irq events
  localparam logic [7:0] REG_MASK   = 8'h10;
  localparam logic [7:0] REG_ERR    = 8'h14; // r: host-side protocol error flags
  // op codes in REG_CMD
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  // pin timing, cycles of ref_clk (100 ns)
  localparam int unsigned T_STROBE_NS = 200;
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  // event bits
  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_ABORT = 1;
  localparam int unsigned EV_ERR   = 2;
  localparam int unsigned EV_W     = 3;

  typedef enum logic [1:0] {
    FAC_IDLE   = 2'b00,
    FAC_SETUP  = 2'b01,
    FAC_STROBE = 2'b10,
    FAC_HOLD   = 2'b11
  } fac_bus_st_t;

  // host view of the overlay the device is in
  typedef enum logic [3:0] {
    FAC_ARRAY  = 4'h0,
    FAC_LOCK   = 4'h1,
    FAC_LOCKPG = 4'h2,
    FAC_LOCKX  = 4'h3,
    FAC_QUERY  = 4'h4,
    FAC_SEC    = 4'h5,
    FAC_SECUL1 = 4'h6,
    FAC_SECUL2 = 4'h7,
    FAC_SECWC  = 4'h8,
    FAC_SECWD  = 4'h9,
    FAC_SECPG  = 4'ha,
    FAC_SECX   = 4'hb,
    FAC_ABORT  = 4'hc
  } fac_view_t;

  // flash pin bundle
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [25:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
  } fac_pins_t;
endpackage

// ==== dv/fac_host_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// watches the controller's apb side and flash pins
module fac_host_checker #(
  parameter int unsigned AW = 26
) (
  // clock and reset
  input wire logic          ref_clk_i,
  input wire logic          rst_n_i,
  // apb
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic [7:0]    paddr_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  // flash pins
  input wire logic          ce_n_o,
  input wire logic          we_n_o,
  input wire logic          oe_n_o,
  input wire logic [AW-1:0] addr_o,
  input wire logic [15:0]   dq_o,
  input wire logic          dq_oe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // apb answers after exactly one wait cycle
  a_pready_one_wait: assert property ($rose(psel_i && penable_i) |-> !pready_o ##1 pready_o)
    else $error("pready not one cycle into access");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready_o && paddr_i > 8'h14 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  // command cycles on the flash pins
  a_strobe_selected: assert property (!we_n_o || !oe_n_o |-> !ce_n_o)
    else $error("strobe low with chip deselected");
  a_one_strobe: assert property (we_n_o || oe_n_o)
    else $error("write and read strobes both low");
  a_write_width: assert property ($fell(we_n_o) |-> !we_n_o [*3] ##1 we_n_o)
    else $error("write strobe width wrong");
  a_ce_after_strobe: assert property ($rose(we_n_o) || $rose(oe_n_o) |-> !ce_n_o ##1 ce_n_o)
    else $error("chip select not released after strobe");
  a_cycle_stable: assert property (!we_n_o && $past(!we_n_o) |-> $stable(addr_o) && $stable(dq_o))
    else $error("address or data moved during write");
  a_drive_on_write: assert property (dq_oe_o |-> !ce_n_o && oe_n_o)
    else $error("data driven outside write cycle");
endmodule
`default_nettype wire

// ==== dv/fac_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// behavioural flash: one-shot status read, array data elsewhere
module fac_flash_model (
  // pins from the controller
  input wire logic        ce_n_i,
  input wire logic        we_n_i,
  input wire logic        oe_n_i,
  input wire logic [25:0] addr_i,
  input wire logic [15:0] dq_i,
  // data back to the controller
  output logic [15:0]     dq_o
);
  localparam logic [15:0] SR_VAL = 16'h0080; // device_ready_bit set, no abort
  logic        sr_pend_q = 1'b0;
  logic [15:0] last_q = 16'h0000;

  // status request taken at the end of the write strobe
  always @(posedge we_n_i) begin
    if (!ce_n_i && addr_i[11:0] == 12'h555 && dq_i[7:0] == 8'h70) begin
      sr_pend_q = 1'b1;
    end
  end
  // a read consumes the pending status, so only one read sees it
  always @(posedge oe_n_i) begin
    last_q = sr_pend_q ? SR_VAL : {4'h5, addr_i[11:0]};
    sr_pend_q = 1'b0;
  end
  // released bus shows the inverse of the last word, never a held value
  always_comb begin
    if (!ce_n_i && !oe_n_i)
      dq_o = sr_pend_q ? SR_VAL : {4'h5, addr_i[11:0]};
    else
      dq_o = ~last_q;
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, irq;
  logic        ce_n, we_n, oe_n, hdq_oe;
  logic [25:0] faddr;
  logic [15:0] hdq, fdq;
  int          failures = 0;
  int          total_checks = 0;
  // start view, address, data, expected view; start f keeps the view
  localparam logic [27:0] TBL [32] = '{
    28'h1123f00, 28'h1555711, 28'h1010a02, 28'h13c0903, 28'h3011000, 28'h3022030,
    28'h4045f00, 28'h4555714, 28'h5100f00, 28'h5555715, 28'h5555aa6, 28'h62aa557,
    28'h6077f00, 28'h73c0f05, 28'h755590b, 28'h7100258, 28'hb099000, 28'h52aa125,
    28'h20abf02, 28'h20ab902, 28'h7100258, 28'hf100019, 28'hf105339, 28'hf28044c,
    28'hf55512c, 28'hf555aa6, 28'hf2aa12c, 28'hf555aa6, 28'hf2aa557, 28'hf000f05,
    28'h7100258, 28'hf20001c};

  always #50 clk = ~clk;

  fac_host #(.AW(26)) u_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(faddr), .dq_o(hdq),
    .dq_oe_o(hdq_oe), .dq_i(hdq_oe ? hdq : fdq), .irq_o(irq));
  fac_flash_model u_flash (
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(faddr), .dq_i(hdq), .dq_o(fdq));

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask
  // poll busy under a bound so a stuck cycle cannot hang the run
  task automatic idle();
    for (int n = 0; n < 50; n++) begin
      apb(1'b0, fac_pkg::REG_STATUS, 32'h0);
      if (rd[16] === 1'b0)
        return;
    end
    failures++;
    wrap_up();
  endtask
  task automatic cmd(input logic [1:0] op, input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, fac_pkg::REG_CMD, {op, 2'b00, a, 8'h00, d});
    idle();
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // overlay transitions, single steps and buffer abort sequences
    foreach (TBL[i]) begin
      if (TBL[i][27:24] !== 4'hf)
        cmd(2'h3, 12'h000, {4'h0, TBL[i][27:24]});
      cmd(fac_pkg::OP_WRITE, TBL[i][23:12], TBL[i][11:4]);
      apb(1'b0, fac_pkg::REG_CMD, 32'h0);
      `CHK(rd[3:0], TBL[i][3:0]) // view
    end
    apb(1'b0, fac_pkg::REG_ERR, 32'h0);
    `CHK(rd[2:0], 3'b111)
    // abort event drives the interrupt only while unmasked
    `CHK(irq, 1'b0)
    apb(1'b1, fac_pkg::REG_MASK, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, fac_pkg::REG_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // status read answers one read, then array data again
    cmd(2'h3, 12'h000, 8'h01);
    cmd(fac_pkg::OP_WRITE, 12'h555, 8'h70);
    cmd(fac_pkg::OP_READ, 12'h0c3, 8'h00);
    apb(1'b0, fac_pkg::REG_RDATA, 32'h0);
    `CHK(rd[15:0], 16'h0080)
    cmd(fac_pkg::OP_READ, 12'h0c3, 8'h00);
    apb(1'b0, fac_pkg::REG_RDATA, 32'h0);
    `CHK(rd[15:0], 16'h50c3)
    apb(1'b0, fac_pkg::REG_CMD, 32'h0);
    `CHK(rd[3:0], 4'h1)
    // second command while the first cycle runs, then an unmapped read
    apb(1'b1, fac_pkg::REG_CMD, {fac_pkg::OP_WRITE, 2'b00, 12'h0aa, 16'h00f0});
    apb(1'b1, fac_pkg::REG_CMD, {fac_pkg::OP_WRITE, 2'b00, 12'h0aa, 16'h00f0});
    `CHK(err, 1'b1)
    idle();
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    // programming ignores reset while not ready, a ready status read ends it
    cmd(fac_pkg::OP_READ, 12'h044, 8'h00);
    cmd(2'h3, 12'h000, 8'h0a);
    cmd(fac_pkg::OP_WRITE, 12'h0aa, 8'hf0);
    apb(1'b0, fac_pkg::REG_CMD, 32'h0);
    `CHK(rd[3:0], 4'ha)
    cmd(fac_pkg::OP_WRITE, 12'h555, 8'h70);
    cmd(fac_pkg::OP_READ, 12'h044, 8'h00);
    apb(1'b0, fac_pkg::REG_CMD, 32'h0);
    `CHK(rd[3:0], 4'h0)
    apb(1'b0, fac_pkg::REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b01)
    apb(1'b0, fac_pkg::REG_ERR, 32'h0);
    `CHK(rd[3], 1'b1)
    wrap_up();
  end
endmodule

bind fac_host fac_host_checker #(.AW(AW)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o));
`default_nettype wire
